// [verilog/pps_regs.svh]
// Constants for the pack power-up sequencer: offsets, resets, timings.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH
// Position of the presence mask word in the default store
`define PPS_ADDR_CELL_MASK 4'h0
// Factory default mask: cells 1, 2 and 8 present (3-cell pack)
`define PPS_CELL_MASK_DEFAULT 8'h83
// Number of words reloaded from the default store
`define PPS_RELOAD_WORDS 16
// Clock period in picoseconds
`define PPS_CLK_PS 5000
// Load check settle wait, ms
`define PPS_LOAD_WAIT_MS 3000
// Load monitor spacing, ms
`define PPS_LOAD_GAP_MS 256
// Normal voltage scan interval, ms
`define PPS_SCAN_MS 32
// Cycles per millisecond at the core clock
`define PPS_CYC_PER_MS (1000000000 / `PPS_CLK_PS)
`endif

// [verilog/pps_pkg.sv]
// Types for the pack power-up sequencer.
// Assumes pps_regs.svh supplies the numbers.
package pps_pkg;
  // Sequencer states, Gray coded along the power-up path
  typedef enum logic [2:0] {
    pps_power_down = 3'b000,
    pps_reload = 3'b001,
    pps_check = 3'b011,
    pps_normal = 3'b010,
    pps_load_wait = 3'b110,
    pps_load_test = 3'b111,
    pps_fets_on = 3'b101
  } pps_state_type;
endpackage : pps_pkg

// [verilog/pps_default_store.sv]
// Small non-volatile default store model: words read out of a register.
// Assumes the surrounding logic holds the address stable for one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"
module pps_default_store #(
  parameter int DEPTH = `PPS_RELOAD_WORDS,
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  ////////////////////////////////////////////////////////////////////////
  // Contents fixed at build; only word 0 carries a nonzero default
  logic [WIDTH-1:0] store [DEPTH];
  if (DEPTH < 2) begin : g_bad_depth
    $error("DEPTH too small");
  end
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
      if (i == `PPS_ADDR_CELL_MASK) begin : g_mask
        assign store[i] = WIDTH'(`PPS_CELL_MASK_DEFAULT);
      end else begin : g_zero
        assign store[i] = '0;
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // Registered read port
  always_ff @(posedge core_clk) begin
    rd_data <= store[rd_addr];
  end
endmodule : pps_default_store
`default_nettype wire

// [verilog/pps_sync.sv]
// Two-flop synchroniser bank for asynchronous level inputs.
// Assumes the inputs are slow levels; pulses shorter than a cycle may vanish.
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH too small");
  end
  always_comb begin
    next_meta = srst ? '0 : async_in;
    next_sync_out = srst ? '0 : meta;
  end
  always_ff @(posedge core_clk) begin
    meta <= next_meta;
    sync_out <= next_sync_out;
  end
endmodule : pps_sync
`default_nettype wire

// [verilog/pps_sequencer.sv]
// Pack power-up sequencer: power-down hold, default reload, cell checks,
// normal monitoring and the load check that gates the power FETs.
// Assumes cell readings, open-wire and fault flags come from the core
// clock domain; supply comparators and sense pins are asynchronous.
// Assumes mask writes come from core-clock logic; writes during the
// reload window are dropped so the stored default always lands.
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"
module pps_sequencer #(
  parameter int CELLS = 8,
  parameter int LOAD_WAIT_CYC = `PPS_LOAD_WAIT_MS * `PPS_CYC_PER_MS,
  parameter int LOAD_GAP_CYC = `PPS_LOAD_GAP_MS * `PPS_CYC_PER_MS,
  parameter int SCAN_CYC = `PPS_SCAN_MS * `PPS_CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic charger_sense_pin,
  input wire logic load_sense_pin,
  input wire logic supply_above_1v,
  input wire logic supply_above_por,
  input wire logic regulator_output_level,
  input wire logic [CELLS-1:0] cell_zero,
  input wire logic [CELLS-1:0] cell_open_wire,
  input wire logic [CELLS-1:0] cell_voltage_ok,
  input wire logic overcurrent,
  input wire logic temp_fault,
  input wire logic mask_wr,
  input wire logic [CELLS-1:0] mask_wdata,
  output logic [CELLS-1:0] cell_presence_mask,
  output logic supplies_on,
  output logic fets_on,
  output logic scan_strobe,
  output logic [CELLS-1:0] convert_enable,
  output logic [CELLS-1:0] balance_enable,
  output logic [CELLS-1:0] cell_missing,
  output logic [2:0] state_code
);
  // Elaboration guard: vectors and store words are one byte wide
  if (CELLS != 8 || LOAD_WAIT_CYC < 1 || LOAD_GAP_CYC < 1 ||
      SCAN_CYC < 1) begin : g_bad_params
    $error("Unsupported sequencer parameters");
  end
  ////////////////////////////////////////////////////////////////////////
  // Pin and comparator synchronisers
  // Comparators may chatter near their thresholds; the two-flop delay
  // is far below any supply time constant, so it costs nothing real
  logic [4:0] sync_bits; // Raw synchroniser outputs
  logic chg_s; // Charger present
  logic load_s; // Load present
  logic vdd_1v_s; // Supply above 1V
  logic vdd_por_s; // Supply above reset threshold
  logic regulator_up_s; // Regulator above 2.25V
  pps_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({charger_sense_pin, load_sense_pin, supply_above_1v,
               supply_above_por, regulator_output_level}),
    .sync_out(sync_bits)
  );
  assign {chg_s, load_s, vdd_1v_s, vdd_por_s, regulator_up_s} = sync_bits;
  ////////////////////////////////////////////////////////////////////////
  // Default store for reload
  // Sixteen words of defaults; the reload index carries one spare bit
  localparam int AW = $clog2(`PPS_RELOAD_WORDS);
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  pps_default_store #(.DEPTH(`PPS_RELOAD_WORDS), .WIDTH(8)) u_store (
    .core_clk(core_clk),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  // Timers are 32 bits: the full settle wait at the core clock needs
  // about thirty of them, and one width keeps the compares simple
  pps_pkg::pps_state_type state;
  pps_pkg::pps_state_type next_state;
  logic [31:0] timer; // General wait counter
  logic [31:0] next_timer;
  logic [31:0] scan_cnt; // Scan interval counter
  logic [31:0] next_scan_cnt;
  logic [AW:0] reload_idx; // Reload word index, one extra for latency
  logic [AW:0] next_reload_idx;
  logic clear_seen; // First load-free sample taken
  logic next_clear_seen;
  logic [CELLS-1:0] next_mask;
  logic [CELLS-1:0] next_missing;
  logic next_supplies_on;
  logic next_fets_on;
  logic next_scan_strobe;
  logic power_fail; // Supply collapse
  logic cells_good; // Every present cell valid
  logic [CELLS-1:0] miss_now;
  // Two-way power-fail condition; above 1V with regulator up holds on.
  // A short pack dip keeps the logic alive on the regulator's hold-up
  // capacitor, so only a real collapse drops the state machine.
  assign power_fail = (!vdd_por_s && !regulator_up_s) ||
                      (!vdd_1v_s && regulator_up_s);
  // Unmarked positions count for neither the missing nor the good term;
  // a zero or an open-wire reading alone flags a cell; open-wire noise is not filtered
  assign miss_now = cell_presence_mask &
                    (cell_open_wire | cell_zero);
  assign cells_good = (miss_now == '0) &&
    ((cell_voltage_ok | ~cell_presence_mask) == '1);
  assign rd_addr = reload_idx[AW-1:0];
  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_scan_cnt = scan_cnt;
    next_reload_idx = reload_idx;
    next_clear_seen = clear_seen;
    next_mask = cell_presence_mask;
    next_missing = cell_missing;
    next_supplies_on = supplies_on;
    next_fets_on = 1'b0;
    next_scan_strobe = 1'b0;
    // Scan tick runs at normal rate whenever supplies are up
    // Errors never slow the scan: one rate in every running state
    if (state != pps_pkg::pps_power_down) begin
      if (scan_cnt >= 32'(SCAN_CYC - 1)) begin
        next_scan_cnt = '0;
        next_scan_strobe = 1'b1;
      end else begin
        next_scan_cnt = scan_cnt + 32'd1;
      end
    end
    // Software may rewrite the mask once running
    // A write in the reload window would race the stored default
    if (mask_wr && state != pps_pkg::pps_reload) begin
      next_mask = mask_wdata;
    end
    case (state)
      pps_pkg::pps_power_down: begin
        next_supplies_on = 1'b0;
        next_scan_cnt = '0;
        // Stay down while the supply is still failing, or supplies would
        // toggle every cycle between reload and power-down
        if (chg_s && !power_fail) begin
          // Charger brings up supplies
          next_supplies_on = 1'b1;
          next_reload_idx = '0;
          next_state = pps_pkg::pps_reload;
        end
      end
      pps_pkg::pps_reload: begin
        // Read data trails address by one cycle
        // One extra index step lets the last word's read data arrive;
        // only word zero carries a field used here
        if (reload_idx != '0 &&
            (reload_idx - 1'b1) == (AW+1)'(`PPS_ADDR_CELL_MASK)) begin
          next_mask = rd_data;
        end
        if (reload_idx == (AW+1)'(`PPS_RELOAD_WORDS)) begin
          next_state = pps_pkg::pps_check;
        end else begin
          next_reload_idx = reload_idx + 1'b1;
        end
      end
      pps_pkg::pps_check: begin
        // Judge readings only on a fresh scan; between scans they are stale
        if (scan_strobe) begin
          next_missing = miss_now;
          if (cells_good) begin
            next_state = pps_pkg::pps_normal;
          end // Otherwise loop on the next scan
        end
      end
      pps_pkg::pps_normal: begin
        // Missing flags keep tracking; load check starts once all good
        if (scan_strobe) begin
          next_missing = miss_now;
        end
        if (cells_good && !overcurrent && !temp_fault) begin
          next_timer = '0;
          next_state = pps_pkg::pps_load_wait;
        end
      end
      pps_pkg::pps_load_wait: begin
        // Settle wait before sampling the load line; any fault aborts
        // back to normal, which restarts the whole wait
        if (!cells_good || overcurrent || temp_fault) begin
          next_state = pps_pkg::pps_normal;
        end else if (timer >= 32'(LOAD_WAIT_CYC - 1)) begin
          next_timer = '0;
          next_clear_seen = 1'b0;
          next_state = pps_pkg::pps_load_test;
        end else begin
          next_timer = timer + 32'd1;
        end
      end
      pps_pkg::pps_load_test: begin
        // Timer zero is a sample slot; a nonzero timer is the gap between
        // samples. Two clear slots in a row are needed, so a load that
        // only flickers clear once keeps the FETs off
        if (!cells_good || overcurrent || temp_fault) begin
          next_state = pps_pkg::pps_normal;
        end else if (timer != '0) begin
          next_timer = (timer >= 32'(LOAD_GAP_CYC - 1)) ? '0 :
                       timer + 32'd1;
        end else if (load_s) begin
          // Load seen: restart pair of clear samples
          next_clear_seen = 1'b0;
          next_timer = 32'd1;
        end else if (clear_seen) begin
          next_fets_on = 1'b1;
          next_state = pps_pkg::pps_fets_on;
        end else begin
          next_clear_seen = 1'b1;
          next_timer = 32'd1;
        end
      end
      pps_pkg::pps_fets_on: begin
        // Load is not re-checked here; faults drop back to normal
        if (cells_good && !overcurrent && !temp_fault) begin
          next_fets_on = 1'b1;
        end else begin
          next_state = pps_pkg::pps_normal;
        end
      end
      default: begin
        // Unused codes recover to power-down
        next_state = pps_pkg::pps_power_down;
      end
    endcase
    // Supply collapse overrides every state branch above; only reset wins over it
    if (state != pps_pkg::pps_power_down && power_fail) begin
      next_state = pps_pkg::pps_power_down;
      next_supplies_on = 1'b0;
      next_fets_on = 1'b0;
    end
    // Synchronous reset last, so it wins over every branch above
    if (srst) begin
      next_state = pps_pkg::pps_power_down;
      next_timer = '0;
      next_scan_cnt = '0;
      next_reload_idx = '0;
      next_clear_seen = 1'b0;
      next_mask = `PPS_CELL_MASK_DEFAULT;
      next_missing = '0;
      next_supplies_on = 1'b0;
      next_fets_on = 1'b0;
      next_scan_strobe = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // State registers; every reset value arrives through the next_ terms,
  // so this process stays plain and carries no branch of its own
  always_ff @(posedge core_clk) begin
    state <= next_state;
    timer <= next_timer;
    scan_cnt <= next_scan_cnt;
    reload_idx <= next_reload_idx;
    clear_seen <= next_clear_seen;
    cell_presence_mask <= next_mask;
    cell_missing <= next_missing;
    supplies_on <= next_supplies_on;
    fets_on <= next_fets_on;
    scan_strobe <= next_scan_strobe;
  end
  ////////////////////////////////////////////////////////////////////////
  // Registered per-cell enables; balancing only while monitoring,
  // so cells are not bled before the pack has passed its checks.
  // Enables follow next_mask so a mask write reaches them with the mask.
  logic run_state;
  assign run_state = (state == pps_pkg::pps_normal) ||
                     (state == pps_pkg::pps_load_wait) ||
                     (state == pps_pkg::pps_load_test) ||
                     (state == pps_pkg::pps_fets_on);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      convert_enable <= '0;
      balance_enable <= '0;
      state_code <= 3'h0;
    end else begin
      convert_enable <= supplies_on ? next_mask : '0;
      balance_enable <= run_state ? next_mask : '0;
      state_code <= next_state;
    end
  end
endmodule : pps_sequencer
`default_nettype wire

// [sim/pps_sequencer_assertions.sv]
// Checker for the pack power-up sequencer, bound to its top module.
// Assumes the bench runs scan strobes every 4 cycles, power steady in check.
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer_checker #(
  parameter int LOAD_WAIT_CYC = 20,
  parameter int LOAD_GAP_CYC = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic charger_sense_pin,
  input wire logic supply_above_1v,
  input wire logic supply_above_por,
  input wire logic regulator_output_level,
  input wire logic [7:0] cell_zero,
  input wire logic [7:0] cell_open_wire,
  input wire logic [7:0] cell_voltage_ok,
  input wire logic overcurrent,
  input wire logic temp_fault,
  input wire logic [7:0] cell_presence_mask,
  input wire logic supplies_on,
  input wire logic fets_on,
  input wire logic scan_strobe,
  input wire logic [7:0] convert_enable,
  input wire logic [7:0] balance_enable,
  input wire logic [7:0] cell_missing,
  input wire logic [2:0] state_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Supply lost: both comparator cases
  wire logic pf = (!supply_above_por && !regulator_output_level) ||
    (!supply_above_1v && regulator_output_level);
  // Any present cell reading bad
  wire logic [7:0] miss_now = cell_presence_mask & (cell_open_wire | cell_zero);
  wire logic bad = |(miss_now | (cell_presence_mask & ~cell_voltage_ok));
  logic [2:0] prev_state; // State one cycle ago
  int st_cnt; // Cycles the state has stood, less one
  int next_st_cnt;
  // Dwell counter, so long waits need no long repetitions
  always_comb next_st_cnt = (state_code == prev_state) ? st_cnt + 1 : 0;
  always_ff @(posedge core_clk) begin
    prev_state <= state_code;
    st_cnt <= srst ? 0 : next_st_cnt;
  end
  ////////////////////////////////////////
  a_convert_mask: assert property (supplies_on && $past(supplies_on) &&
    $stable(cell_presence_mask) |-> convert_enable == cell_presence_mask)
    else $error("convert enables differ from mask");
  a_balance_mask: assert property (state_code inside {2, 6, 7, 5} &&
    prev_state inside {2, 6, 7, 5} && $stable(cell_presence_mask)
    |-> balance_enable == cell_presence_mask)
    else $error("balance enables differ from mask");
  a_hold_down: assert property ((state_code == 3'd0 &&
    !charger_sense_pin)[*4] |=> state_code == 3'd0)
    else $error("left power down without charger");
  a_charger_start: assert property (state_code == 3'd0 &&
    charger_sense_pin && !pf |=> ##[0:2] state_code == 3'd1)
    else $error("charger did not start reload");
  a_reload_len: assert property (state_code == 3'd1 &&
    prev_state != 3'd1 |-> ##17 state_code == 3'd3)
    else $error("reload length wrong");
  a_reload_mask: assert property (state_code == 3'd3 &&
    prev_state == 3'd1 |-> cell_presence_mask == 8'h83)
    else $error("mask not reloaded to default");
  a_check_loop: assert property (state_code == 3'd3 && scan_strobe &&
    bad && !pf |=> state_code == 3'd3)
    else $error("left check with bad readings");
  a_missing_flag: assert property (state_code == 3'd3 &&
    scan_strobe |=> cell_missing == $past(miss_now))
    else $error("missing flags wrong");
  a_fault_off: assert property (fets_on && (overcurrent ||
    temp_fault) |=> !fets_on)
    else $error("fets stayed on through fault");
  a_wait_len: assert property (state_code == 3'd7 &&
    prev_state == 3'd6 |-> st_cnt == LOAD_WAIT_CYC - 1)
    else $error("load wait too short");
  a_load_pair: assert property ($rose(fets_on) |-> state_code == 3'd5 &&
    prev_state == 3'd7 && st_cnt >= LOAD_GAP_CYC)
    else $error("fets on without two load samples");
  a_power_fail: assert property (pf[*3] |=> ##[0:2]
    (state_code == 3'd0 && !fets_on))
    else $error("no power down on supply loss");
  a_scan_gap: assert property (scan_strobe |=> !scan_strobe[*3])
    else $error("scan strobes too close");
endmodule : pps_sequencer_checker
bind pps_sequencer pps_sequencer_checker #(.LOAD_WAIT_CYC(LOAD_WAIT_CYC),
  .LOAD_GAP_CYC(LOAD_GAP_CYC)) pps_sequencer_checker_i (.core_clk, .srst,
  .charger_sense_pin, .supply_above_1v, .supply_above_por,
  .regulator_output_level, .cell_zero, .cell_open_wire, .cell_voltage_ok,
  .overcurrent, .temp_fault, .cell_presence_mask, .supplies_on, .fets_on,
  .scan_strobe, .convert_enable, .balance_enable, .cell_missing, .state_code);
`default_nettype wire

// [sim/pps_pack_model.sv]
// Far-side pack model: cell taps, charger and load sense lines.
// Assumes the bench says which taps are wired and whether a load hangs on.
`timescale 1ns/1ps
`default_nettype none
module pps_pack_model (
  input wire logic core_clk,
  input wire logic [7:0] wired,
  input wire logic charger_in,
  input wire logic load_in,
  output logic charger_sense_pin,
  output logic load_sense_pin,
  output logic [7:0] cell_zero,
  output logic [7:0] cell_open_wire,
  output logic [7:0] cell_voltage_ok
);
  int noise_seed = 7; // Own seed, apart from the bench's
  ////////////////////////////////////////
  initial {charger_sense_pin, load_sense_pin, cell_zero} = '0;
  initial {cell_open_wire, cell_voltage_ok} = '0;
  // Unwired taps read zero; the open-wire result on them is noisy,
  // so missing cells must be caught by either test alone
  // Changes land just after the rising edge, off the bench's own edge
  always @(posedge core_clk) begin
    charger_sense_pin <= charger_in;
    load_sense_pin <= load_in;
    cell_zero <= ~wired;
    cell_open_wire <= ~wired & 8'($random(noise_seed));
    cell_voltage_ok <= wired;
  end
endmodule : pps_pack_model
`default_nettype wire

// [sim/tb_pps_sequencer.sv]
// Self-checking bench for the pack power-up sequencer.
// Assumes the pack model on the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_pps_sequencer;
  localparam int WAIT = 20; // Short load settle wait
  localparam int GAP = 8; // Short load sample spacing
  logic core_clk = 1'b1; // First fall at 2.5 ns
  logic srst = 1'b1;
  logic charger_in = 1'b0, load_in = 1'b1, mask_wr = 1'b0;
  logic supply_above_1v = 1'b1, supply_above_por = 1'b1;
  logic regulator_output_level = 1'b1;
  logic overcurrent = 1'b0, temp_fault = 1'b0;
  logic [7:0] wired = 8'h00, mask_wdata = 8'h00;
  logic charger_sense_pin, load_sense_pin, supplies_on, fets_on, scan_strobe;
  logic [7:0] cell_zero, cell_open_wire, cell_voltage_ok, cell_presence_mask;
  logic [7:0] convert_enable, balance_enable, cell_missing;
  logic [2:0] state_code;
  int fails = 0, checks = 0, seed = 19099, strobes = 0;
  always #2.5 core_clk = ~core_clk;
  pps_sequencer #(.LOAD_WAIT_CYC(WAIT), .LOAD_GAP_CYC(GAP), .SCAN_CYC(4))
    pps_sequencer_i (.core_clk, .srst, .charger_sense_pin, .load_sense_pin,
    .supply_above_1v, .supply_above_por, .regulator_output_level, .cell_zero,
    .cell_open_wire, .cell_voltage_ok, .overcurrent, .temp_fault, .mask_wr,
    .mask_wdata, .cell_presence_mask, .supplies_on, .fets_on, .scan_strobe,
    .convert_enable, .balance_enable, .cell_missing, .state_code);
  pps_pack_model pps_pack_model_i (.core_clk, .wired, .charger_in, .load_in,
    .charger_sense_pin, .load_sense_pin, .cell_zero, .cell_open_wire,
    .cell_voltage_ok);
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Bounded wait on the state code, then compare
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && state_code !== s; i++) cyc(1);
    `CHK("state", s, state_code)
  endtask : wait_state
  // Strobes seen in 40 samples, one per cycle; 10 at a scan every 4
  task automatic scan_count(output int n);
    n = 0;
    repeat (40) begin
      cyc(1);
      n += int'(scan_strobe);
    end
  endtask : scan_count
  // Cells flagged: present by mask but not wired
  function automatic logic [7:0] exp_missing(input logic [7:0] m, w);
    return m & ~w;
  endfunction : exp_missing
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // Watchdog well past the expected run length
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    cyc(17);
    srst = 1'b0;
    wired = 8'hfd; // Cell 2 left off
    cyc(40);
    `CHK("state", 3'd0, state_code)
    `CHK("supplies", 1'b0, supplies_on)
    `CHK("mask", 8'h83, cell_presence_mask)
    charger_in = 1'b1;
    wait_state(3'd3, 40);
    `CHK("supplies", 1'b1, supplies_on)
    `CHK("convert", 8'h83, convert_enable)
    // Random wirings lacking cell 2 keep the check looping
    repeat (6) begin
      wired = 8'($random(seed)) & 8'hfd;
      cyc(12);
      `CHK("missing", exp_missing(8'h83, wired), cell_missing)
      `CHK("state", 3'd3, state_code)
    end
    scan_count(strobes);
    `CHK("scans", 10, strobes)
    wired = 8'h83; // Only the default three cells
    wait_state(3'd6, 20);
    `CHK("missing", 8'h00, cell_missing)
    wait_state(3'd7, WAIT + 5);
    cyc(5 * GAP);
    `CHK("fets", 1'b0, fets_on)
    load_in = 1'b0;
    cyc(3);
    `CHK("fets", 1'b0, fets_on)
    wait_state(3'd5, 3 * GAP + 5);
    `CHK("fets", 1'b1, fets_on)
    scan_count(strobes);
    `CHK("scans", 10, strobes)
    wired = 8'hff;
    // Mask writes: the example pattern, then random ones
    for (int k = 0; k < 3; k++) begin
      mask_wdata = (k == 0) ? 8'hcf : 8'($random(seed));
      mask_wr = 1'b1;
      cyc(1);
      mask_wr = 1'b0;
      cyc(3);
      `CHK("mask", mask_wdata, cell_presence_mask)
      `CHK("balance", mask_wdata, balance_enable)
    end
    // Each fault in turn drops the fets
    for (int f = 0; f < 2; f++) begin
      wait_state(3'd5, WAIT + 6 * GAP);
      {overcurrent, temp_fault} = f ? 2'b10 : 2'b01;
      cyc(2);
      `CHK("fets", 1'b0, fets_on)
      {overcurrent, temp_fault} = 2'b00;
    end
    wait_state(3'd5, WAIT + 6 * GAP);
    supply_above_por = 1'b0; // Regulator still up
    cyc(10);
    `CHK("fets", 1'b1, fets_on)
    regulator_output_level = 1'b0;
    cyc(6);
    `CHK("state", 3'd0, state_code)
    `CHK("fets", 1'b0, fets_on)
    {supply_above_por, regulator_output_level} = 2'b11;
    wait_state(3'd3, 40);
    `CHK("mask", 8'h83, cell_presence_mask)
    final_report();
  end
endmodule : tb_pps_sequencer
`default_nettype wire
